// ==== pkg/rom_image_defines.svh ====
// offsets, field values and sizes of the expansion rom image
`ifndef ROM_IMAGE_DEFINES_SVH
`define ROM_IMAGE_DEFINES_SVH
`define ROM_SIZE_BYTES    4096
`define ROM_ADDR_W        12
`define ROM_SIG0_OFS      12'h000
`define ROM_SIG1_OFS      12'h001
`define ROM_INIT_SIZE_OFS 12'h002
`define ROM_ENTRY_OFS     12'h003
`define ROM_PTR_LO_OFS    12'h018
`define ROM_PTR_HI_OFS    12'h019
`define ROM_SIG0_VAL      8'h55
`define ROM_SIG1_VAL      8'hAA
`define DS_SIG_P          8'h50
`define DS_SIG_C          8'h43
`define DS_SIG_I          8'h49
`define DS_SIG_R          8'h52
`define DS_VEND_OFS       5'h04
`define DS_DEV_OFS        5'h06
`define DS_VPD_OFS        5'h08
`define DS_LEN_OFS        5'h0A
`define DS_REV_OFS        5'h0C
`define DS_CLASS_OFS      5'h0D
`define DS_IMGLEN_OFS     5'h10
`define DS_CODEREV_OFS    5'h12
`define DS_CODETYPE_OFS   5'h14
`define DS_IND_OFS        5'h15
`define DS_RSVD_OFS       5'h16
`define DS_REV_VAL        8'h00
`define DS_CLASS_VAL      24'h00020C
`define DS_IMGLEN_VAL     16'h0008
`define DS_IND_VAL        8'h80
`define DS_SPAN           5'h18
`define VPD_LEN_BYTES     135
`define UNIT_512          512
`endif

// ==== pkg/rom_image_pkg.sv ====
// types shared by the expansion rom image logic
package rom_image_pkg;
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } rom_req_t;
  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [7:0] data;
  } rom_rsp_t;
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_COPY = 2'b01,
    LD_DONE = 2'b11
  } load_state_t;
endpackage

// ==== hw/rom_sram.sv ====
// byte-wide image sram holding the flash copy
`timescale 1ns/100ps
module rom_sram #(
  parameter int ADDR_W = 12
) (
  input  wire logic              ref_clk_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] waddr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic [ADDR_W-1:0] raddr_i,
  output logic      [7:0]        rdata_o
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule // rom_sram

// ==== hw/expansion_rom_image.sv ====
// expansion rom image: flash to sram copy, layout check, host read window
// Function
// - copy flash to sram each reset, serve reads
// - image byte zero maps at programmed base
// - rom window is 4 KB, one image
// - header first, structure at header pointer
// - bytes 0,1 hold 55h then AAh
// - byte 2 is code size in 512s
// - bytes 3 to 5 hold entry point
// - bytes 18h,19h little-endian structure pointer
// - structure starts on 32-bit boundary
// - structure starts with ascii PCIR
// - vendor and device ids match config
// - vpd offset at 8,9, 135 bytes
// - structure length at Ah,Bh little-endian
// - structure revision byte is zero
// - class code 00020Ch at Dh to Fh
// - image length 0008h at 10h
// - code revision and code type zero
// - indicator byte 80h marks last image
`timescale 1ns/100ps
`include "rom_image_defines.svh"
module expansion_rom_image
  import rom_image_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID  = 16'h0A5A, // arbitrary value
  parameter logic [15:0] DEVICE_ID  = 16'h0C3C, // arbitrary value
  parameter logic [23:0] CLASS_CODE = `DS_CLASS_VAL
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  output logic             flash_rd_o,
  output logic [11:0]      flash_addr_o,
  input  wire logic [7:0]  flash_data_i,
  input  wire logic        flash_valid_i,
  input  wire logic [31:0] rom_base_i,
  input  wire rom_req_t    host_req_i,
  output rom_rsp_t         host_rsp_o,
  output logic             load_done_o,
  output logic             image_ok_o
);
  localparam int AW = `ROM_ADDR_W;

  ////////////////////////////////////////////////////////////////////////////
  // flash copy: one byte per flash answer, reads held off until done
  load_state_t state;
  logic [AW:0] copy_cnt;
  logic        wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0]  wr_data;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state        <= LD_IDLE;
      copy_cnt     <= '0;
      flash_rd_o   <= 1'b0;
      flash_addr_o <= 12'h000;
    end else begin
      unique case (state)
        LD_IDLE: begin
          state      <= LD_COPY;
          flash_rd_o <= 1'b1;
          flash_addr_o <= 12'h000;
        end
        LD_COPY: begin
          if (flash_valid_i) begin
            if (copy_cnt[AW-1:0] == {AW{1'b1}}) begin
              state      <= LD_DONE;
              flash_rd_o <= 1'b0;
            end else begin
              flash_addr_o <= flash_addr_o + 12'h001;
            end
            copy_cnt <= copy_cnt + 1'b1;
          end
        end
        LD_DONE: begin
          state <= LD_DONE;
        end
        default: state <= LD_IDLE;
      endcase
    end
  end

  // the write uses the address of the byte just answered
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_en   <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
    end else begin
      wr_en   <= (state == LD_COPY) && flash_valid_i;
      wr_addr <= flash_addr_o;
      wr_data <= flash_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // layout check as bytes stream past; needs the pointer before the structure
  logic [15:0] ds_ptr;
  logic        ok;

  function automatic logic [7:0] ds_expect(input logic [4:0] ofs);
    unique case (ofs)
      5'h00: ds_expect = `DS_SIG_P;
      5'h01: ds_expect = `DS_SIG_C;
      5'h02: ds_expect = `DS_SIG_I;
      5'h03: ds_expect = `DS_SIG_R;
      5'h04: ds_expect = VENDOR_ID[7:0];
      5'h05: ds_expect = VENDOR_ID[15:8];
      5'h06: ds_expect = DEVICE_ID[7:0];
      5'h07: ds_expect = DEVICE_ID[15:8];
      5'h0C: ds_expect = `DS_REV_VAL;
      5'h0D: ds_expect = CLASS_CODE[7:0];
      5'h0E: ds_expect = CLASS_CODE[15:8];
      5'h0F: ds_expect = CLASS_CODE[23:16];
      5'h10: ds_expect = 8'(`DS_IMGLEN_VAL);
      5'h11: ds_expect = 8'(`DS_IMGLEN_VAL >> 8);
      5'h15: ds_expect = `DS_IND_VAL;
      default: ds_expect = 8'h00;
    endcase
  endfunction

  // bytes 8..Bh and 16h..17h carry image-specific values, not checked
  function automatic logic ds_checked(input logic [4:0] ofs);
    ds_checked = !((ofs >= `DS_VPD_OFS && ofs <= 5'h0B) || ofs >= `DS_RSVD_OFS);
  endfunction

  logic [AW-1:0] rel;
  assign rel = wr_addr - ds_ptr[AW-1:0];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ds_ptr <= 16'h0000;
    end else if (wr_en && wr_addr == `ROM_PTR_LO_OFS) begin
      ds_ptr[7:0] <= wr_data;
    end else if (wr_en && wr_addr == `ROM_PTR_HI_OFS) begin
      ds_ptr[15:8] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ok <= 1'b1;
    end else if (wr_en) begin
      if (wr_addr == `ROM_SIG0_OFS && wr_data != `ROM_SIG0_VAL) begin
        ok <= 1'b0;
      end
      if (wr_addr == `ROM_SIG1_OFS && wr_data != `ROM_SIG1_VAL) begin
        ok <= 1'b0;
      end
      if (wr_addr == `ROM_PTR_HI_OFS) begin
        // pointer must stay inside 4 KB, be 32-bit aligned, follow header
        if ({wr_data, ds_ptr[7:0]} >= 16'(`ROM_SIZE_BYTES - 32'(`DS_SPAN))) begin
          ok <= 1'b0;
        end
        if (ds_ptr[1:0] != 2'b00) begin
          ok <= 1'b0;
        end
        if ({wr_data, ds_ptr[7:0]} <= 16'h001A) begin
          ok <= 1'b0;
        end
      end
      if (wr_addr > `ROM_PTR_HI_OFS && rel < AW'(`DS_SPAN) && ds_checked(rel[4:0])
          && wr_data != ds_expect(rel[4:0])) begin
        ok <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_done_o <= 1'b0;
      image_ok_o  <= 1'b0;
    end else begin
      load_done_o <= (state == LD_DONE) && !wr_en;
      image_ok_o  <= (state == LD_DONE) && !wr_en && ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host reads: offset from base, 4 KB window, bytes 2..5 etc. served as loaded
  logic [31:0]   offs;
  logic          in_win;
  logic          rd_pend;
  logic          rd_hit;
  logic [7:0]    rd_data;

  assign offs   = host_req_i.addr - rom_base_i;
  assign in_win = offs < 32'(`ROM_SIZE_BYTES);

  rom_sram #(.ADDR_W(AW)) u_sram (
    .ref_clk_i (ref_clk_i),
    .we_i      (wr_en),
    .waddr_i   (wr_addr),
    .wdata_i   (wr_data),
    .raddr_i   (offs[AW-1:0]),
    .rdata_o   (rd_data)
  );

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_pend <= 1'b0;
      rd_hit  <= 1'b0;
    end else begin
      rd_pend <= host_req_i.valid && load_done_o;
      rd_hit  <= in_win;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_rsp_o <= '0;
    end else begin
      host_rsp_o.valid <= rd_pend;
      host_rsp_o.hit   <= rd_pend && rd_hit;
      // size, entry point, product data offset and length are served exactly as loaded
      host_rsp_o.data  <= (rd_pend && rd_hit) ? rd_data : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_copy_bound: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(load_done_o) |-> copy_cnt == (AW+1)'(`ROM_SIZE_BYTES))
    else $error("load done before whole image copied");
  a_no_early_rd: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    host_rsp_o.valid |-> $past(load_done_o, 2))
    else $error("host read answered before load");
  a_read_lat: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (host_req_i.valid && load_done_o) |-> ##2 host_rsp_o.valid)
    else $error("read answer not two cycles later");
  a_window_hit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (host_req_i.valid && load_done_o && !in_win) |-> ##2 !host_rsp_o.hit)
    else $error("hit outside rom window");
  a_base_map: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (host_req_i.valid && load_done_o && host_req_i.addr == rom_base_i)
      |-> ##2 host_rsp_o.hit)
    else $error("base address not mapped to byte zero");
  a_sig_bad: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_en && wr_addr == `ROM_SIG0_OFS && wr_data != `ROM_SIG0_VAL) |=> !ok)
    else $error("bad signature not flagged");
  a_align_bad: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_en && wr_addr == `ROM_PTR_HI_OFS && ds_ptr[1:0] != 2'b00) |=> !ok)
    else $error("unaligned structure not flagged");
  a_ind_bad: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_en && wr_addr > `ROM_PTR_HI_OFS && rel == AW'(`DS_IND_OFS)
      && wr_data != `DS_IND_VAL) |=> !ok)
    else $error("bad indicator not flagged");
  a_ok_sticky: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !ok |=> !ok)
    else $error("layout error cleared without reset");
endmodule // expansion_rom_image

// ==== tb/flash_model.sv ====
// flash model that hands the image to the copy engine one byte at a time
`timescale 1ns/100ps
module flash_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rd_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [1:0]  gap_i,
  output logic      [7:0]  data_o,
  output logic             valid_o
);
  logic [7:0] mem [4096];
  logic [1:0] idle;
  initial begin
    valid_o = 1'b0;
    data_o  = 8'h00;
    idle    = 2'h0;
  end
  // idle data toggles so a stale byte never passes for a real one
  always @(posedge ref_clk_i) begin
    #1;
    if (valid_o || !rd_i || idle != 2'h0) begin
      data_o  = ~data_o;
      idle    = valid_o ? gap_i : (idle != 2'h0 ? idle - 2'h1 : idle);
      valid_o = 1'b0;
    end else begin
      valid_o = 1'b1;
      data_o  = mem[addr_i];
    end
  end
endmodule // flash_model

// ==== tb/tb_top.sv ====
// self-checking bench for the expansion rom image block
`timescale 1ns/100ps
module tb_top;
  import rom_image_pkg::*;
  localparam logic [15:0] VEND   = 16'h0A5A; // arbitrary value
  localparam logic [15:0] DEVI   = 16'h0C3C; // arbitrary value
  localparam logic [31:0] BASE_A = 32'h000C_8000;
  localparam logic [31:0] BASE_B = 32'h000C_A000;
  logic        ref_clk_i;
  logic        resetn_i;
  logic        flash_rd;
  logic        flash_valid;
  logic        load_done;
  logic        image_ok;
  logic [11:0] flash_addr;
  logic [7:0]  flash_data;
  logic [1:0]  gap;
  logic [31:0] rom_base;
  rom_req_t    host_req;
  rom_rsp_t    host_rsp;
  logic [7:0]  img [4096];
  int          failures;
  int          cmp_count;

  expansion_rom_image #(.VENDOR_ID(VEND), .DEVICE_ID(DEVI)) u_expansion_rom_image (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .flash_rd_o(flash_rd),
    .flash_addr_o(flash_addr), .flash_data_i(flash_data), .flash_valid_i(flash_valid),
    .rom_base_i(rom_base), .host_req_i(host_req), .host_rsp_o(host_rsp),
    .load_done_o(load_done), .image_ok_o(image_ok));
  flash_model u_flash_model (.ref_clk_i(ref_clk_i), .rd_i(flash_rd), .addr_i(flash_addr),
    .gap_i(gap), .data_o(flash_data), .valid_o(flash_valid));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chkv(input logic [31:0] act, input logic [31:0] exp, input string what);
    cmp_count++;
    if (act !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic chk1(input logic act, input logic exp, input string what);
    chkv({31'h0, act}, {31'h0, exp}, what);
  endtask
  task automatic put(input int i, input logic [7:0] v);
    img[i] = v;
    u_flash_model.mem[i] = v;
  endtask
  // structure at 1Ch, code of seven 512-byte units, product data right after it
  task automatic build_image();
    logic [7:0] ds [24] = '{8'h50, 8'h43, 8'h49, 8'h52, VEND[7:0], VEND[15:8], DEVI[7:0],
      DEVI[15:8], 8'h00, 8'h0E, 8'h18, 8'h00, 8'h00, 8'h0C, 8'h02, 8'h00, 8'h08, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
    for (int i = 0; i < 4096; i++) put(i, 8'(i) ^ 8'h3C);
    put(0, 8'h55);
    put(1, 8'hAA);
    put(2, 8'h07);
    put(24, 8'h1C);
    put(25, 8'h00);
    for (int k = 0; k < 24; k++) put(28 + k, ds[k]);
  endtask
  task automatic chk_rsp(input logic [31:0] a);
    logic [31:0] off;
    off = a - rom_base;
    chk1(host_rsp.valid, 1'b1, "no response");
    chk1(host_rsp.hit, off < 32'd4096, "hit flag");
    chkv(32'(host_rsp.data), off < 32'd4096 ? 32'(img[off[11:0]]) : 32'h0, "byte");
  endtask
  // two reads on consecutive edges, each answered one edge after the edge that takes it
  task automatic rd2(input logic [31:0] a0, input logic [31:0] a1);
    host_req = '{1'b1, a0};
    @(posedge ref_clk_i) #1;
    chk1(host_rsp.valid, 1'b0, "early answer");
    host_req.addr = a1;
    @(posedge ref_clk_i) #1;
    host_req.valid = 1'b0;
    chk_rsp(a0);
    @(posedge ref_clk_i) #1;
    chk_rsp(a1);
    @(posedge ref_clk_i) #1;
    chk1(host_rsp.valid, 1'b0, "extra answer");
  endtask
  // host keeps asking all through the copy; nothing may be answered
  task automatic t_load(input logic exp_ok);
    int n;
    @(posedge ref_clk_i) #1;
    resetn_i = 1'b0;
    host_req = '{1'b1, rom_base};
    repeat (16) @(posedge ref_clk_i);
    #1;
    chk1(flash_rd | load_done | image_ok | host_rsp.valid, 1'b0, "busy in reset");
    resetn_i = 1'b1;
    @(posedge ref_clk_i) #1;
    chk1(flash_rd, 1'b1, "copy not started");
    chkv(32'(flash_addr), 32'h0, "copy start");
    n = 0;
    while (load_done !== 1'b1 && n < 20000) begin
      chk1(host_rsp.valid, 1'b0, "answer before load");
      @(posedge ref_clk_i) #1;
      n++;
    end
    host_req.valid = 1'b0;
    chk1(load_done, 1'b1, "load unfinished");
    chk1(image_ok, exp_ok, "layout verdict");
    // let an edge pass so the next request is not raised in the step that dropped it
    @(posedge ref_clk_i) #1;
  endtask
  task automatic t_bad(input int i, input logic [7:0] v);
    logic [7:0] keep;
    keep = img[i];
    put(i, v);
    t_load(1'b0);
    put(i, keep);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // about 75k cycles are needed; cut off at 90k
  initial begin
    #720000;
    failures++;
    give_verdict();
  end
  initial begin
    resetn_i = 1'b0;
    gap = 2'h0;
    rom_base = BASE_A;
    host_req = '0;
    failures = 0;
    cmp_count = 0;
    build_image();
    t_load(1'b1);
    for (int i = 0; i < 4096; i += 2) begin
      rd2(BASE_A + i, BASE_A + i + 1);
    end
    rd2(BASE_A - 32'd1, BASE_A + 32'd4096);
    rd2(BASE_A + 32'd4095, BASE_A);
    rom_base = BASE_B;
    rd2(BASE_B, BASE_A);
    rom_base = BASE_A;
    gap = 2'h2;
    t_bad(49, 8'h00);
    gap = 2'h0;
    t_bad(1, 8'hA5);
    t_bad(24, 8'h1E);
    t_bad(24, 8'h18);
    t_bad(25, 8'h10);
    t_load(1'b1);
    rd2(BASE_A + 32'd49, BASE_A + 32'd24);
    give_verdict();
  end
endmodule // tb_top
